// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import tsc_pkg::*;
;
    localparam logic [7:0] RPTR [4] = '{8'h03, 8'h04, 8'h1A, 8'h0F};
    localparam logic [7:0] REXP [4] = '{8'h00, 8'h08, 8'h1C, 8'h00};
    localparam logic [2:0] CSEL [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic       clk, rst_b, wr_stb, rd_stb, rd_hit, h;
    logic       lhf, rhf, rv, lle, rle, aclr, oe, pend, start, done, busy, rext, pin_o;
    logic [7:0] ptr, wdata, rdata, d;
    logic [2:0] csel;
    logic [1:0] lres;
    int         n;
    int         mismatches;
    int         cmp_count;
    tsc_conv_ctrl #(
        .CONV_BASE_CYCLES     (16),
        .SLOWEST_PERIOD_CYCLES(4096)
    ) i_tsc_conv_ctrl (
        .CLK(clk), .RST_B(rst_b), .WR_STB(wr_stb), .RD_STB(rd_stb), .PTR(ptr),
        .WDATA(wdata), .RDATA(rdata), .RD_HIT(rd_hit), .LOCAL_HIGH_FLAG(lhf),
        .REMOTE_HIGH_FLAG(rhf), .RESULT_VALID(rv), .LOCAL_LIMIT_EXCEEDED(lle),
        .REMOTE_LIMIT_EXCEEDED(rle), .CONSEC_SEL(csel), .ALERT_CLEAR(aclr),
        .ALERT_PIN_O(pin_o), .ALERT_PIN_OE(oe), .ALERT_PENDING(pend), .CONV_START(start),
        .CONV_DONE(done), .CONV_BUSY(busy), .RANGE_EXT(rext), .LOCAL_RES(lres)
    );
    tsc_host_model i_tsc_host_model (
        .clk(clk), .rdata(rdata), .rd_hit(rd_hit), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .ptr(ptr), .wdata(wdata)
    );
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(ref logic s, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (s !== 1'b1 && k < 6000);
        if (k >= 6000) begin
            mismatches++;
            $display("CHECK FAILED t=%0t wait timeout", $time);
        end
    endtask
    task automatic pulse(input logic l, input logic r);
        @(negedge clk);
        rv  = 1'b1;
        lle = l;
        rle = r;
        @(negedge clk);
        rv  = 1'b0;
    endtask
    task automatic clr();
        @(negedge clk);
        aclr = 1'b1;
        @(negedge clk);
        aclr = 1'b0;
        @(negedge clk);
        chk(8'(pend), 8'h00);
        chk(8'(oe), 8'h00);
    endtask
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        finish_test();
    end
    initial begin
        clk   = 1'b0;
        rst_b = 1'b0;
        {lhf, rhf, rv, lle, rle, aclr} = 6'h00;
        csel  = 3'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            i_tsc_host_model.rd(RPTR[i], d, h);
            chk(d, REXP[i]);
            chk(8'(h), 8'(i < 3));
        end
        i_tsc_host_model.wr(PTR_CFG_RD, 8'h40);
        i_tsc_host_model.rd(PTR_CFG_RD, d, h);
        chk(d, 8'h00);
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h84);
        i_tsc_host_model.rd(PTR_CFG_RD, d, h);
        chk(d, 8'h84);
        chk(8'(rext), 8'h01);
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h00);
        i_tsc_host_model.wr(PTR_PREC, 8'h03);
        i_tsc_host_model.rd(PTR_PREC, d, h);
        chk(d, 8'h1F);
        chk(8'(lres), 8'h03);
        i_tsc_host_model.wr(PTR_PREC, 8'h00);
        i_tsc_host_model.wr(PTR_PACE_WR, 8'h06);
        i_tsc_host_model.rd(PTR_PACE_RD, d, h);
        chk(d, 8'h06);
        for (int k = 0; k < 4; k++) begin
            csel = CSEL[k];
            pulse(1'b0, 1'b0);
            repeat (k) pulse(!k[0], k[0]);
            chk(8'(pend), 8'h00);
            pulse(!k[0], k[0]);
            chk(8'(pend), 8'h01);
            @(negedge clk);
            chk(8'(oe), 8'h01);
            clr();
        end
        csel = 3'h0;
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h80);
        pulse(1'b1, 1'b0);
        @(negedge clk);
        chk(8'(pend), 8'h01);
        chk(8'(oe), 8'h00);
        clr();
        i_tsc_host_model.wr(PTR_CFG_WR, 8'hA0);
        for (int k = 0; k < 4; k++) begin
            {lhf, rhf} = 2'(k);
            repeat (2) @(negedge clk);
            chk(8'(oe), 8'(k != 0));
            chk(8'(pin_o), 8'h00);
        end
        {lhf, rhf} = 2'b00;
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h00);
        for (int c = 0; c < 8; c++) begin
            i_tsc_host_model.wr(PTR_PACE_WR, 8'(c));
            wait_hi(start, n);
            wait_hi(start, n);
            chk(8'(n >= (4096 >> c) && n <= (4096 >> c) + 3), 8'h01);
        end
        i_tsc_host_model.wr(PTR_PACE_WR, 8'h05);
        i_tsc_host_model.wr(PTR_PREC, 8'h01);
        wait_hi(start, n);
        wait_hi(done, n);
        chk(8'(n), 8'h20);
        wait_hi(start, n);
        chk(8'(n >= 96 && n <= 99), 8'h01);
        wait_hi(start, n);
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h40);
        chk(8'(busy), 8'h01);
        wait_hi(done, n);
        n = 0;
        repeat (300) begin
            @(negedge clk);
            n += int'(start);
        end
        chk(8'(n), 8'h00);
        for (int r = 0; r < 4; r++) begin
            i_tsc_host_model.wr(PTR_PREC, 8'(r));
            i_tsc_host_model.wr(PTR_TRIGGER, 8'hA5);
            // the start pulse already stands when the write returns
            chk(8'(start), 8'h01);
            wait_hi(done, n);
            chk(8'(n), 8'(16 << r));
        end
        i_tsc_host_model.rd(PTR_CFG_RD, d, h);
        chk(d, 8'h40);
        i_tsc_host_model.wr(PTR_CFG_WR, 8'h00);
        wait_hi(start, n);
        chk(8'(n <= 3), 8'h01);
        finish_test();
    end
endmodule

// file: dv/tsc_conv_monitor.sv
`timescale 1ns/10ps
module tsc_conv_monitor
    import tsc_pkg::*;
#(
    parameter int unsigned CONV_BASE_CYCLES = 16
) (
    input wire logic       CLK,
    input wire logic       RST_B,
    input wire logic       WR_STB,
    input wire logic       RD_STB,
    input wire logic [7:0] PTR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic       RD_HIT,
    input wire logic       LOCAL_HIGH_FLAG,
    input wire logic       REMOTE_HIGH_FLAG,
    input wire logic       RESULT_VALID,
    input wire logic       LOCAL_LIMIT_EXCEEDED,
    input wire logic [2:0] CONSEC_SEL,
    input wire logic       ALERT_PIN_OE,
    input wire logic       ALERT_PENDING,
    input wire logic       CONV_START,
    input wire logic       CONV_DONE,
    input wire logic       CONV_BUSY,
    input wire logic [1:0] LOCAL_RES
);
    logic [7:0]  cfg_q;
    logic [31:0] cnt_q;
    logic [1:0]  res_q;
    logic [1:0]  res_p;
    logic        trig;
    logic        hit;
    assign trig = WR_STB && PTR == PTR_TRIGGER;
    assign hit  = PTR == PTR_CFG_RD || PTR == PTR_PACE_RD || PTR == PTR_PREC;
    // shadow of the configuration byte and length of the running conversion
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_q <= CFG_RST;
            cnt_q <= 32'h0;
            res_q <= 2'h0;
            res_p <= 2'h0;
        end else begin
            if (WR_STB && PTR == PTR_CFG_WR) begin
                cfg_q <= WDATA;
            end
            res_p <= LOCAL_RES;
            if (CONV_START) begin
                cnt_q <= 32'h1;
                // precision was latched one edge before the start pulse
                res_q <= res_p;
            end else if (CONV_BUSY) begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
    default clocking mon_cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    a_start_busy: assert property (CONV_START |-> CONV_BUSY)
        else $error("start without busy");
    a_done_ends: assert property (CONV_DONE |-> !CONV_BUSY && $past(CONV_BUSY))
        else $error("done outside conversion");
    a_conv_time: assert property (CONV_DONE |-> cnt_q == (CONV_BASE_CYCLES << res_q))
        else $error("conversion length wrong");
    a_read_hit: assert property (RD_HIT == $past(RD_STB && hit))
        else $error("read hit wrong");
    a_cfg_read: assert property (RD_STB && PTR == PTR_CFG_RD |=>
        RDATA == ($past(cfg_q) & 8'hE4))
        else $error("config readback wrong");
    a_pend_one: assert property (RESULT_VALID && LOCAL_LIMIT_EXCEEDED &&
        CONSEC_SEL == 3'h0 |=> ALERT_PENDING)
        else $error("pending not raised");
    a_alert_drive: assert property ($past(!cfg_q[5] && !cfg_q[7]) |->
        ALERT_PIN_OE == $past(ALERT_PENDING))
        else $error("alert pin wrong");
    a_mask_quiet: assert property ($past(!cfg_q[5] && cfg_q[7]) |-> !ALERT_PIN_OE)
        else $error("masked pin driven");
    a_critical_thermal_pin_pin: assert property ($past(cfg_q[5]) |->
        ALERT_PIN_OE == $past(LOCAL_HIGH_FLAG || REMOTE_HIGH_FLAG))
        else $error("thermal pin wrong");
    a_sd_quiet: assert property ($past(cfg_q[6]) && $past(cfg_q[6], 2) &&
        !$past(trig) && !$past(trig, 2) |-> !CONV_START)
        else $error("start in shutdown");
endmodule

bind tsc_conv_ctrl tsc_conv_monitor #(
    .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) i_tsc_conv_monitor (
    .CLK, .RST_B, .WR_STB, .RD_STB, .PTR, .WDATA, .RDATA, .RD_HIT,
    .LOCAL_HIGH_FLAG, .REMOTE_HIGH_FLAG, .RESULT_VALID, .LOCAL_LIMIT_EXCEEDED,
    .CONSEC_SEL, .ALERT_PIN_OE, .ALERT_PENDING, .CONV_START, .CONV_DONE,
    .CONV_BUSY, .LOCAL_RES
);

// file: dv/tsc_host_model.sv
`timescale 1ns/10ps
module tsc_host_model
    import tsc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rd_hit,
    output      logic       wr_stb,
    output      logic       rd_stb,
    output      logic [7:0] ptr,
    output      logic [7:0] wdata
);
    realtime sd_at;
    logic    first;
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        ptr    = 8'h00;
        wdata  = 8'h00;
        first  = 1'b0;
        sd_at  = 0;
    end
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (p == PTR_CFG_WR) begin
            v = d & 8'hE4;
            if (v[CFG_SD_BIT]) begin
                first = 1'b1;
                sd_at = $realtime;
            end
        end
        if (p == PTR_PREC) begin
            v = 8'h1C | (d & 8'h03);
        end
        // margin covers the conversion that finishes before shutdown
        if (p == PTR_TRIGGER && first) begin
            while ($realtime < sd_at + 202000.0) @(negedge clk);
            first = 1'b0;
        end
        @(negedge clk);
        wr_stb = 1'b1;
        ptr    = p;
        wdata  = v;
        @(negedge clk);
        wr_stb = 1'b0;
        ptr    = ~p;
        wdata  = ~v;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic h);
        @(negedge clk);
        rd_stb = 1'b1;
        ptr    = p;
        @(negedge clk);
        d      = rdata;
        h      = rd_hit;
        rd_stb = 1'b0;
        ptr    = ~p;
    endtask
endmodule

// file: inc/tsc_pkg.sv
package tsc_pkg;

    localparam int  CLK_PERIOD_NS     = 10;
    localparam real CONV_BASE_MS      = 12.5;
    localparam int  CONV_BASE_CYC     = int'(CONV_BASE_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam real SLOWEST_RATE_HZ   = 0.0625;
    localparam int  SLOWEST_PERIOD_CYC =
        int'(1.0e9 / (SLOWEST_RATE_HZ * CLK_PERIOD_NS));

    localparam logic [7:0] PTR_CFG_RD  = 8'h03;
    localparam logic [7:0] PTR_CFG_WR  = 8'h09;
    localparam logic [7:0] PTR_PACE_RD = 8'h04;
    localparam logic [7:0] PTR_PACE_WR = 8'h0A;
    localparam logic [7:0] PTR_TRIGGER = 8'h0F;
    localparam logic [7:0] PTR_PREC    = 8'h1A;

    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] PACE_RST = 8'h08;
    localparam logic [7:0] PREC_RST = 8'h1C;

    localparam int CFG_MASK_BIT  = 7;
    localparam int CFG_SD_BIT    = 6;
    localparam int CFG_PINF_BIT  = 5;
    localparam int CFG_RANGE_BIT = 2;
    localparam int PREC_LSB      = 0;

    localparam logic [7:0] PACE_MAX_CODE = 8'h07;
    localparam logic [2:0] CONSEC_MAX    = 3'h4;

    typedef struct packed {
        logic alert_mask;
        logic shutdown_bit;
        logic pin_function_select;
        logic range_ext;
    } tsc_cfg_type;

    typedef enum logic [1:0] {
        S_BOOT = 2'b00,
        S_CONV = 2'b01,
        S_IDLE = 2'b10,
        S_SHDN = 2'b11
    } tsc_state_type;

    function automatic tsc_cfg_type cfg_unpack(input logic [7:0] b);
        tsc_cfg_type c;
        c.alert_mask          = b[CFG_MASK_BIT];
        c.shutdown_bit        = b[CFG_SD_BIT];
        c.pin_function_select = b[CFG_PINF_BIT];
        c.range_ext           = b[CFG_RANGE_BIT];
        return c;
    endfunction

    function automatic logic [7:0] cfg_pack(input tsc_cfg_type c);
        logic [7:0] b;
        b                = 8'h00;
        b[CFG_MASK_BIT]  = c.alert_mask;
        b[CFG_SD_BIT]    = c.shutdown_bit;
        b[CFG_PINF_BIT]  = c.pin_function_select;
        b[CFG_RANGE_BIT] = c.range_ext;
        return b;
    endfunction

    // 000->1, 001->2, 011->3, 111->4; other codes fall back to one
    function automatic logic [2:0] consec_need(input logic [2:0] sel);
        logic [2:0] n;
        unique case (sel)
            3'h1:    n = 3'h2;
            3'h3:    n = 3'h3;
            3'h7:    n = CONSEC_MAX;
            default: n = 3'h1;
        endcase
        return n;
    endfunction

endpackage

// file: rtl/tsc_alert_filter.sv
`timescale 1ns/10ps
module tsc_alert_filter
    import tsc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       result_valid,
    input  wire logic       local_ool,
    input  wire logic       remote_ool,
    input  wire logic [2:0] consec_sel,
    input  wire logic       clear,
    output      logic       pending
);

    typedef struct packed {
        logic [2:0] lcnt;
        logic [2:0] rcnt;
        logic       pend;
    } tsc_flt_type;

    tsc_flt_type s_q;
    tsc_flt_type s_d;

    function automatic logic [2:0] bump(input logic ool, input logic [2:0] c);
        logic [2:0] r;
        r = 3'h0;
        if (ool) begin
            r = (c >= CONSEC_MAX) ? CONSEC_MAX : c + 3'h1;
        end
        return r;
    endfunction

    always_comb begin
        logic [2:0] need;
        logic       hit;
        need = consec_need(consec_sel);
        hit  = 1'b0;
        s_d  = s_q;
        if (result_valid) begin
            s_d.lcnt = bump(local_ool, s_q.lcnt);
            s_d.rcnt = bump(remote_ool, s_q.rcnt);
            hit      = (s_d.lcnt >= need) || (s_d.rcnt >= need);
        end
        // a new hit in the clearing cycle keeps the condition set
        if (hit) begin
            s_d.pend = 1'b1;
        end else if (clear) begin
            s_d.pend = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pending = s_q.pend;

endmodule

// file: rtl/tsc_conv_ctrl.sv
`timescale 1ns/10ps
module tsc_conv_ctrl
    import tsc_pkg::*;
#(
    parameter int unsigned CONV_BASE_CYCLES  = CONV_BASE_CYC,
    parameter int unsigned SLOWEST_PERIOD_CYCLES = SLOWEST_PERIOD_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RST_B,
    // pointer register access from the two-wire front end
    input  wire logic       WR_STB,
    input  wire logic       RD_STB,
    input  wire logic [7:0] PTR,
    input  wire logic [7:0] WDATA,
    output      logic [7:0] RDATA,
    output      logic       RD_HIT,
    // comparator side
    input  wire logic       LOCAL_HIGH_FLAG,
    input  wire logic       REMOTE_HIGH_FLAG,
    input  wire logic       RESULT_VALID,
    input  wire logic       LOCAL_LIMIT_EXCEEDED,
    input  wire logic       REMOTE_LIMIT_EXCEEDED,
    input  wire logic [2:0] CONSEC_SEL,
    input  wire logic       ALERT_CLEAR,
    // shared open-drain alert / high-limit thermal pin
    output      logic       ALERT_PIN_O,
    output      logic       ALERT_PIN_OE,
    output      logic       ALERT_PENDING,
    // converter control
    output      logic       CONV_START,
    output      logic       CONV_DONE,
    output      logic       CONV_BUSY,
    output      logic       RANGE_EXT,
    output      logic [1:0] LOCAL_RES
);

    generate
        if (CONV_BASE_CYCLES < 2) begin : g_chk_conv
            $error("conversion base count must be at least two");
        end
        if (CONV_BASE_CYCLES > 32'h0FFF_FFFF) begin : g_chk_conv_w
            $error("conversion count overflows timer");
        end
        if (SLOWEST_PERIOD_CYCLES < 128) begin : g_chk_per
            $error("slowest period too short for the pace codes");
        end
    endgenerate

    localparam logic [31:0] BASE_C = 32'(CONV_BASE_CYCLES);
    localparam logic [31:0] SLOW_C = 32'(SLOWEST_PERIOD_CYCLES);

    typedef struct packed {
        tsc_state_type st;
        tsc_cfg_type   cfg;
        logic [7:0]    pace;
        logic [7:0]    prec;
        logic [1:0]    conv_res;
        logic [7:0]    rdata;
        logic          rd_hit;
        logic          start;
        logic          done;
        logic          busy;
        logic          pin_oe;
    } tsc_ctrl_type;

    tsc_ctrl_type s_q;
    tsc_ctrl_type s_d;

    logic        tmr_load;
    logic [31:0] tmr_val;
    logic        tmr_exp;
    logic        alert_pend;

    function automatic logic [31:0] conv_cycles(input logic [1:0] res);
        return BASE_C << res;
    endfunction

    function automatic logic [31:0] idle_cycles(input logic [7:0] code,
                                                input logic [1:0] res);
        logic [7:0]  sh;
        logic [31:0] per;
        logic [31:0] cv;
        sh  = (code > PACE_MAX_CODE) ? PACE_MAX_CODE : code;
        per = SLOW_C >> sh[2:0];
        cv  = conv_cycles(res);
        // only the gap shrinks or grows; a too-slow conversion leaves a one-cycle gap
        return (per > cv) ? per - cv : 32'h0000_0001;
    endfunction

    tsc_interval_timer #(
        .W        (32)
    ) u_timer (
        .clk      (CLK),
        .rst_b    (RST_B),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_exp)
    );

    tsc_alert_filter u_filter (
        .clk          (CLK),
        .rst_b        (RST_B),
        .result_valid (RESULT_VALID),
        .local_ool    (LOCAL_LIMIT_EXCEEDED),
        .remote_ool   (REMOTE_LIMIT_EXCEEDED),
        .consec_sel   (CONSEC_SEL),
        .clear        (ALERT_CLEAR),
        .pending      (alert_pend)
    );

    always_comb begin
        logic trig_req;
        logic go;
        trig_req = 1'b0;
        go       = 1'b0;
        tmr_load = 1'b0;
        tmr_val  = 32'h0000_0000;
        s_d        = s_q;
        s_d.start  = 1'b0;
        s_d.done   = 1'b0;
        s_d.rd_hit = 1'b0;

        // register writes
        if (WR_STB) begin
            unique case (PTR)
                PTR_CFG_WR: begin
                    s_d.cfg = cfg_unpack(WDATA);
                end
                PTR_PACE_WR: begin
                    s_d.pace = WDATA;
                end
                PTR_PREC: begin
                    s_d.prec = WDATA;
                end
                PTR_TRIGGER: begin
                    // data byte is dropped on purpose
                    trig_req = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // register reads; pointers owned elsewhere answer with no hit
        if (RD_STB) begin
            s_d.rd_hit = 1'b1;
            unique case (PTR)
                PTR_CFG_RD: begin
                    s_d.rdata = cfg_pack(s_q.cfg);
                end
                PTR_PACE_RD: begin
                    s_d.rdata = s_q.pace;
                end
                PTR_PREC: begin
                    s_d.rdata = s_q.prec;
                end
                default: begin
                    s_d.rdata  = 8'h00;
                    s_d.rd_hit = 1'b0;
                end
            endcase
        end

        // conversion sequencing
        unique case (s_q.st)
            S_BOOT: begin
                go = 1'b1;
            end
            S_CONV: begin
                if (tmr_exp) begin
                    s_d.done = 1'b1;
                    s_d.busy = 1'b0;
                    if (s_q.cfg.shutdown_bit) begin
                        s_d.st = S_SHDN;
                    end else begin
                        s_d.st   = S_IDLE;
                        tmr_load = 1'b1;
                        tmr_val  = idle_cycles(s_q.pace, s_q.conv_res);
                    end
                end
            end
            S_IDLE: begin
                if (s_q.cfg.shutdown_bit) begin
                    s_d.st = S_SHDN;
                end else if (tmr_exp) begin
                    go = 1'b1;
                end
            end
            S_SHDN: begin
                if (!s_q.cfg.shutdown_bit) begin
                    go = 1'b1;
                end else if (trig_req) begin
                    go = 1'b1;
                end
            end
        endcase

        if (go) begin
            s_d.st       = S_CONV;
            s_d.start    = 1'b1;
            s_d.busy     = 1'b1;
            s_d.conv_res = s_q.prec[PREC_LSB +: 2];
            tmr_load     = 1'b1;
            // done is registered one edge after expiry, so the timer runs one short
            tmr_val      = conv_cycles(s_q.prec[PREC_LSB +: 2]) - 32'h1;
        end

        // pin function
        if (s_q.cfg.pin_function_select) begin
            // flags are live comparator levels with hysteresis
            s_d.pin_oe = LOCAL_HIGH_FLAG || REMOTE_HIGH_FLAG;
        end else begin
            s_d.pin_oe = alert_pend && !s_q.cfg.alert_mask;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_q.st       <= S_BOOT;
            s_q.cfg      <= cfg_unpack(CFG_RST);
            s_q.pace     <= PACE_RST;
            s_q.prec     <= PREC_RST;
            s_q.conv_res <= 2'h0;
            s_q.rdata    <= 8'h00;
            s_q.rd_hit   <= 1'b0;
            s_q.start    <= 1'b0;
            s_q.done     <= 1'b0;
            s_q.busy     <= 1'b0;
            s_q.pin_oe   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA         = s_q.rdata;
    assign RD_HIT        = s_q.rd_hit;
    assign ALERT_PIN_O   = 1'b0;
    assign ALERT_PIN_OE  = s_q.pin_oe;
    assign ALERT_PENDING = alert_pend;
    assign CONV_START    = s_q.start;
    assign CONV_DONE     = s_q.done;
    assign CONV_BUSY     = s_q.busy;
    assign RANGE_EXT     = s_q.cfg.range_ext;
    assign LOCAL_RES     = s_q.prec[PREC_LSB +: 2];

endmodule

// file: rtl/tsc_interval_timer.sv
`timescale 1ns/10ps
module tsc_interval_timer
    import tsc_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output      logic         expired
);

    generate
        if (W < 8) begin : g_chk
            $error("timer width too small");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         exp;
    } tsc_tmr_type;

    tsc_tmr_type s_q;
    tsc_tmr_type s_d;

    always_comb begin
        s_d     = s_q;
        s_d.exp = 1'b0;
        if (load) begin
            s_d.cnt = (load_val == '0) ? W'(1) : load_val;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - W'(1);
            s_d.exp = (s_q.cnt == W'(1));
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.exp;

endmodule
